// ---- rtl/pfr_top.sv ----
/*
 * Pulse input flow measurement with threshold relay control: glitch
 * filter, adaptive measurement window with divider, relay deciders with
 * delays and alarm override, beeper latch.
 * Assumes configuration ports are quasi-static on clk; pulse_in and
 * button_press are asynchronous pins; serial strobes come from clk logic.
 */
`timescale 1ns/1ns

module pfr_top
    import pfr_pkg::*;
#(
    parameter int NREL = 4,
    parameter int CLK_MHZ = 50,
    parameter int TENTH_CYC = TENTH_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins
    input wire logic pulse_in,
    input wire logic button_press,
    // input and flow configuration
    input wire logic [3:0] max_pulse_rate_setting,
    input wire logic [pfr_pkg::PPU_W-1:0] pulses_per_unit_factor,
    input wire logic [19:0] flow_scale_coefficient,
    input wire logic [2:0] flow_scale_point,
    input wire logic [pfr_pkg::TMO_W-1:0] refresh_window_min,
    input wire logic [pfr_pkg::TMO_W-1:0] no_flow_timeout,
    input wire logic peak_clear,
    // external counters
    input wire logic [pfr_pkg::VAL_W-1:0] batch_count,
    input wire logic [pfr_pkg::VAL_W-1:0] total_count,
    // relay configuration
    input wire logic [NREL-1:0][2:0] relay_mode,
    input wire logic [NREL-1:0][1:0] relay_source,
    input wire logic [NREL-1:0][pfr_pkg::SP_W-1:0] first_threshold,
    input wire logic [NREL-1:0][pfr_pkg::SP_W-1:0] second_threshold,
    input wire logic [NREL-1:0][pfr_pkg::SP_W-1:0] relay_band_half_width,
    input wire logic [NREL-1:0][pfr_pkg::DLY_W-1:0] relay_on_delay,
    input wire logic [NREL-1:0][pfr_pkg::DLY_W-1:0] relay_off_delay,
    input wire logic [NREL-1:0] relay_delay_minutes,
    input wire logic [NREL-1:0][1:0] critical_reaction,
    // serial side
    input wire logic serial_cmd_valid,
    input wire logic [NREL-1:0] serial_cmd_state,
    input wire logic serial_rx_activity,
    input wire logic [pfr_pkg::TMO_W-1:0] serial_silence_timeout,
    // beeper configuration
    input wire logic critical_beep_enable,
    input wire logic [NREL-1:0] relay_beep_enable,
    // outputs
    output logic [pfr_pkg::VAL_W-1:0] flow_value,
    output logic flow_valid,
    output logic [pfr_pkg::VAL_W-1:0] flow_peak,
    output logic [NREL-1:0] relay_out,
    output logic [NREL-1:0] relay_led,
    output logic [NREL-1:0] relay_critical,
    output logic over_rate,
    output logic beeper
);
    import pfr_pkg::*;

    // ************************************************************
    // synchronisers and time base
    // ************************************************************
    logic pin_meta, pin_sync, btn_meta, btn_sync, btn_prev;
    logic [31:0] tenth_cnt;
    logic tenth_tick, min_tick;
    logic [5:0] min_cnt;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            btn_meta <= 1'b0;
            btn_sync <= 1'b0;
            btn_prev <= 1'b0;
        end else begin
            pin_meta <= pulse_in;
            pin_sync <= pin_meta;
            btn_meta <= button_press;
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
        end
    end

    // min_tick marks one tenth of a minute for delay counting
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tenth_cnt <= '0;
            tenth_tick <= 1'b0;
            min_cnt <= '0;
            min_tick <= 1'b0;
        end else begin
            tenth_tick <= (tenth_cnt == 32'(TENTH_CYC - 1));
            min_tick <= 1'b0;
            if (tenth_cnt == 32'(TENTH_CYC - 1)) begin
                tenth_cnt <= '0;
                if (min_cnt == 6'(TENTHS_PER_MIN_TENTH - 1)) begin
                    min_cnt <= '0;
                    min_tick <= 1'b1;
                end else begin
                    min_cnt <= min_cnt + 6'h01;
                end
            end else begin
                tenth_cnt <= tenth_cnt + 32'h1;
            end
        end
    end

    // ************************************************************
    // glitch filter and over-rate detection
    // ************************************************************
    logic [3:0] rate_idx;
    logic [PER_W-1:0] min_state_cyc, min_period_cyc, state_cnt, per_cnt;
    logic filt, filt_prev, pulse_edge;

    assign rate_idx = (max_pulse_rate_setting > RATE_LAST) ? RATE_LAST
                      : max_pulse_rate_setting;
    assign min_state_cyc = PER_W'(MIN_STATE_US[rate_idx] * CLK_MHZ);
    assign min_period_cyc = PER_W'(MIN_PERIOD_US[rate_idx] * CLK_MHZ);
    assign pulse_edge = filt & ~filt_prev;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filt <= 1'b0;
            filt_prev <= 1'b0;
            state_cnt <= '0;
        end else begin
            filt_prev <= filt;
            if (pin_sync == filt) begin
                state_cnt <= '0;
            end else if (state_cnt >= min_state_cyc - PER_W'(1)) begin
                filt <= pin_sync;
                state_cnt <= '0;
            end else begin
                state_cnt <= state_cnt + PER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            per_cnt <= '0;
            over_rate <= 1'b0;
        end else if (pulse_edge) begin
            over_rate <= (per_cnt < min_period_cyc);
            per_cnt <= '0;
        end else begin
            if (per_cnt != '1) begin
                per_cnt <= per_cnt + PER_W'(1);
            end
            if (per_cnt >= min_period_cyc) begin
                over_rate <= 1'b0;
            end
        end
    end

    // ************************************************************
    // measurement window
    // ************************************************************
    logic [PCNT_W-1:0] win_pulses;
    logic [TICK_W-1:0] win_ticks, idle_ticks, idle_limit;
    logic [TICK_W-1:0] win_min;
    logic win_end, no_flow;
    logic [PCNT_W-1:0] done_pulses;
    logic [TICK_W-1:0] done_ticks;

    assign win_min = (refresh_window_min == '0) ? TICK_W'(1)
                     : TICK_W'(refresh_window_min);
    assign idle_limit = (TICK_W'(no_flow_timeout) < win_min) ? win_min
                        : TICK_W'(no_flow_timeout);

    // window closes only once a pulse is in
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_pulses <= '0;
            win_ticks <= '0;
            idle_ticks <= '0;
            win_end <= 1'b0;
            no_flow <= 1'b0;
            done_pulses <= '0;
            done_ticks <= '0;
        end else begin
            win_end <= 1'b0;
            no_flow <= 1'b0;
            if (tenth_tick) begin
                if (win_pulses != '0 && win_ticks + TICK_W'(1) >= win_min)
                begin
                    win_end <= 1'b1;
                    done_pulses <= win_pulses + PCNT_W'(pulse_edge);
                    done_ticks <= win_ticks + TICK_W'(1);
                    win_pulses <= '0;
                    win_ticks <= '0;
                end else begin
                    win_pulses <= win_pulses + PCNT_W'(pulse_edge);
                    win_ticks <= win_ticks + TICK_W'(1);
                end
                if (idle_ticks + TICK_W'(1) >= idle_limit && !pulse_edge)
                begin
                    no_flow <= 1'b1;
                    win_pulses <= '0;
                    win_ticks <= '0;
                end
                idle_ticks <= pulse_edge ? '0 : idle_ticks + TICK_W'(1);
            end else if (pulse_edge) begin
                win_pulses <= win_pulses + PCNT_W'(1);
                idle_ticks <= '0;
            end
        end
    end

    // ************************************************************
    // flow division
    // ************************************************************
    typedef enum {PFR_IDLE, PFR_DIV} pfr_div_t;
    pfr_div_t div_state;
    logic [63:0] div_den, div_quo;
    logic [64:0] div_rem, rem_sh;
    logic [6:0] div_step;
    logic [PPU_W-1:0] ppu_eff;

    assign ppu_eff = (pulses_per_unit_factor == '0) ? PPU_ZERO_AS
                     : pulses_per_unit_factor;
    assign rem_sh = {div_rem[63:0], div_quo[63]};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_state <= PFR_IDLE;
            div_den <= '0;
            div_quo <= '0;
            div_rem <= '0;
            div_step <= '0;
            flow_value <= '0;
            flow_valid <= 1'b0;
        end else begin
            flow_valid <= 1'b0;
            unique case (div_state)
                PFR_IDLE: begin
                    if (no_flow) begin
                        flow_value <= '0;
                        flow_valid <= 1'b1;
                    end else if (win_end) begin
                        div_quo <= 64'(done_pulses) *
                                   64'(flow_scale_coefficient) *
                                   64'(NUM_SCALE);
                        div_den <= 64'(done_ticks) * 64'(ppu_eff) *
                                   64'(POW10[(flow_scale_point > 3'h6) ?
                                   3'h6 : flow_scale_point]);
                        div_rem <= '0;
                        div_step <= '0;
                        div_state <= PFR_DIV;
                    end
                end
                PFR_DIV: begin
                    if (rem_sh >= {1'b0, div_den}) begin
                        div_rem <= rem_sh - {1'b0, div_den};
                        div_quo <= {div_quo[62:0], 1'b1};
                    end else begin
                        div_rem <= rem_sh;
                        div_quo <= {div_quo[62:0], 1'b0};
                    end
                    div_step <= div_step + 7'h01;
                    if (div_step == 7'(DIV_STEPS - 1)) begin
                        div_state <= PFR_IDLE;
                        flow_valid <= 1'b1;
                        // saturate rather than wrap a huge rate
                        flow_value <= (div_quo[62:31] != '0) ? '1
                                      : {div_quo[30:0], 1'b0} |
                                        VAL_W'(rem_sh >= {1'b0, div_den});
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flow_peak <= '0;
        end else if (peak_clear) begin
            flow_peak <= '0;
        end else if (flow_valid && flow_value > flow_peak) begin
            flow_peak <= flow_value;
        end
    end

    // ************************************************************
    // serial silence watch
    // ************************************************************
    logic [TICK_W-1:0] silence_cnt;
    logic silence;
    logic [NREL-1:0] serial_state;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            silence_cnt <= '0;
            silence <= 1'b0;
        end else if (serial_rx_activity) begin
            silence_cnt <= '0;
            silence <= 1'b0;
        end else if (tenth_tick) begin
            if (silence_cnt != '1) begin
                silence_cnt <= silence_cnt + TICK_W'(1);
            end
            silence <= (silence_cnt >= TICK_W'(serial_silence_timeout));
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_state <= '0;
        end else if (serial_cmd_valid) begin
            serial_state <= serial_cmd_state;
        end
    end

    // ************************************************************
    // relay deciders
    // ************************************************************
    // band modes sort the two thresholds into lo and hi
    for (genvar g = 0; g < NREL; g++) begin : g_relay
        logic [VAL_W-1:0] val;
        logic [VAL_W+1:0] v, lo, hi, h;
        logic req_on, req_off, crit, dly_tick;
        logic [DLY_W-1:0] on_cnt, off_cnt;

        always_comb begin
            unique case (relay_source[g])
                SRC_FLOW: val = flow_value;
                SRC_PEAK: val = flow_peak;
                SRC_BATCH: val = (g == 0) ? batch_count : flow_value;
                default: val = total_count;
            endcase
        end

        assign v = (VAL_W+2)'(val);
        assign h = (VAL_W+2)'(relay_band_half_width[g]);
        assign lo = (VAL_W+2)'((first_threshold[g] < second_threshold[g])
                    ? first_threshold[g] : second_threshold[g]);
        assign hi = (VAL_W+2)'((first_threshold[g] < second_threshold[g])
                    ? second_threshold[g] : first_threshold[g]);

        // band spans threshold plus and minus h
        always_comb begin
            req_on = 1'b0;
            req_off = 1'b0;
            unique case (relay_mode[g])
                MODE_ENERGISE: begin
                    req_on = v > (VAL_W+2)'(first_threshold[g]) + h;
                    req_off = v + h < (VAL_W+2)'(first_threshold[g]);
                end
                MODE_DEENERGISE: begin
                    req_off = v > (VAL_W+2)'(first_threshold[g]) + h;
                    req_on = v + h < (VAL_W+2)'(first_threshold[g]);
                end
                MODE_INSIDE: begin
                    req_on = (v > lo + h) && (v + h < hi);
                    req_off = (v > hi + h) || (v + h < lo);
                end
                // off inside, on beyond widened band
                MODE_OUTSIDE: begin
                    req_off = (v > lo + h) && (v + h < hi);
                    req_on = (v > hi + h) || (v + h < lo);
                end
                default: begin
                    req_on = 1'b0;
                    req_off = 1'b0;
                end
            endcase
        end

        assign crit = (relay_mode[g] == MODE_SERIAL) ? silence
                      : (relay_mode[g] != MODE_DISABLED) && over_rate;
        assign dly_tick = relay_delay_minutes[g] ? min_tick : tenth_tick;

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                on_cnt <= '0;
                off_cnt <= '0;
            end else begin
                if (!req_on || relay_out[g]) begin
                    on_cnt <= '0;
                end else if (dly_tick && on_cnt != '1) begin
                    on_cnt <= on_cnt + DLY_W'(1);
                end
                if (!req_off || !relay_out[g]) begin
                    off_cnt <= '0;
                end else if (dly_tick && off_cnt != '1) begin
                    off_cnt <= off_cnt + DLY_W'(1);
                end
            end
        end

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                relay_out[g] <= 1'b0;
                relay_led[g] <= 1'b0;
                relay_critical[g] <= 1'b0;
            end else begin
                relay_critical[g] <= crit;
                relay_led[g] <= relay_out[g];
                if (relay_mode[g] == MODE_DISABLED) begin
                    relay_out[g] <= 1'b0;
                end else if (crit && critical_reaction[g] == REACT_ON) begin
                    relay_out[g] <= 1'b1;
                end else if (crit && critical_reaction[g] == REACT_OFF) begin
                    relay_out[g] <= 1'b0;
                end else if (crit) begin
                    relay_out[g] <= relay_out[g];
                end else if (relay_mode[g] == MODE_SERIAL) begin
                    relay_out[g] <= serial_state[g];
                end else if (req_on && !relay_out[g] &&
                             on_cnt >= relay_on_delay[g]) begin
                    relay_out[g] <= 1'b1;
                end else if (req_off && relay_out[g] &&
                             off_cnt >= relay_off_delay[g]) begin
                    relay_out[g] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // beeper
    // ************************************************************
    logic [NREL-1:0] relay_prev;
    logic crit_prev, beep_set;

    assign beep_set = (critical_beep_enable && |relay_critical && !crit_prev)
                      || |(relay_out & ~relay_prev & relay_beep_enable);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            relay_prev <= '0;
            crit_prev <= 1'b0;
            beeper <= 1'b0;
        end else begin
            relay_prev <= relay_out;
            crit_prev <= |relay_critical;
            // set beats a simultaneous press
            if (beep_set) begin
                beeper <= 1'b1;
            end else if (btn_sync && !btn_prev) begin
                beeper <= 1'b0;
            end
        end
    end

endmodule : pfr_top

// ---- rtl/pfr_pkg.sv ----
/*
 * Shared constants for the pulse flow front end with relay control:
 * mode, reaction and source codes, rate tables and scale figures.
 * Assumes a single clock domain; the tenth count is derived here, rate counts in the module.
 */
package pfr_pkg;

    // ************************************************************
    // field widths
    // ************************************************************
    localparam int SP_W = 20;
    localparam int VAL_W = 32;
    localparam int DLY_W = 10;
    localparam int TMO_W = 9;
    localparam int PPU_W = 20;
    localparam int PCNT_W = 24;
    localparam int TICK_W = 16;
    localparam int PER_W = 24;

    // ************************************************************
    // relay modes, alarm reactions, value sources
    // ************************************************************
    localparam logic [2:0] MODE_DISABLED = 3'h0;
    localparam logic [2:0] MODE_ENERGISE = 3'h1;
    localparam logic [2:0] MODE_DEENERGISE = 3'h2;
    localparam logic [2:0] MODE_INSIDE = 3'h3;
    localparam logic [2:0] MODE_OUTSIDE = 3'h4;
    localparam logic [2:0] MODE_SERIAL = 3'h5;

    localparam logic [1:0] REACT_KEEP = 2'h0;
    localparam logic [1:0] REACT_ON = 2'h1;
    localparam logic [1:0] REACT_OFF = 2'h2;

    localparam logic [1:0] SRC_FLOW = 2'h0;
    localparam logic [1:0] SRC_PEAK = 2'h1;
    localparam logic [1:0] SRC_BATCH = 2'h2;
    localparam logic [1:0] SRC_TOTAL = 2'h3;

    // ************************************************************
    // timing figures
    // ************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int TENTH_MS = 100;
    localparam int TENTH_CYCLES = TENTH_MS * (CLK_HZ / 1000);
    localparam int TENTHS_PER_MIN_TENTH = 60;

    // rate settings 10 Hz .. 10 kHz, index 0..10
    localparam logic [3:0] RATE_LAST = 4'ha;
    localparam logic [16:0] MIN_STATE_US [11] = '{
        17'd5000, 17'd3400, 17'd2500, 17'd1700, 17'd1300, 17'd1000,
        17'd500, 17'd167, 17'd50, 17'd33, 17'd33};
    localparam logic [16:0] MIN_PERIOD_US [11] = '{
        17'd100000, 17'd66667, 17'd50000, 17'd33334, 17'd25000,
        17'd20000, 17'd10000, 17'd3334, 17'd1000, 17'd334, 17'd100};

    // ************************************************************
    // scaling
    // ************************************************************
    localparam logic [PPU_W-1:0] PPU_ZERO_AS = 20'd1000000;
    localparam logic [9:0] NUM_SCALE = 10'd1000;
    localparam logic [19:0] POW10 [7] = '{
        20'd1, 20'd10, 20'd100, 20'd1000, 20'd10000, 20'd100000,
        20'd1000000};
    localparam int DIV_STEPS = 64;

endpackage : pfr_pkg

// ---- bench/pfr_props.sv ----
/* Port checker for pfr_top: relays, leds, flow strobe, beeper.
   Bound below to every pfr_top; one clock, async active-low reset. */
`timescale 1ns/1ns
module pfr_props import pfr_pkg::*; #(parameter int NREL = 4) (
    // clock, reset and watched ports
    input wire logic clk,
    input wire logic resetn,
    input wire logic button_press,
    input wire logic [NREL-1:0][2:0] relay_mode,
    input wire logic [NREL-1:0][1:0] critical_reaction,
    input wire logic [pfr_pkg::VAL_W-1:0] flow_value,
    input wire logic flow_valid,
    input wire logic [NREL-1:0] relay_out,
    input wire logic [NREL-1:0] relay_led,
    input wire logic [NREL-1:0] relay_critical,
    input wire logic beeper
);
    logic dis, f_on, f_off;
    assign dis = relay_mode[0] == MODE_DISABLED;
    assign f_on = relay_critical[0] && critical_reaction[0] == REACT_ON;
    assign f_off = relay_critical[0] && critical_reaction[0] == REACT_OFF;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_off; dis [*2] |-> !relay_out[0]; endproperty
    a_off: assert property (p_off) else $error("disabled relay on");
    property p_calm; dis [*2] |-> !relay_critical[0]; endproperty
    a_calm: assert property (p_calm) else $error("critical off");
    property p_led; relay_led == $past(relay_out); endproperty
    a_led: assert property (p_led) else $error("led lag");
    property p_strobe; flow_valid |=> !flow_valid; endproperty
    a_strobe: assert property (p_strobe) else $error("long strobe");
    property p_hold; !flow_valid |-> $stable(flow_value); endproperty
    a_hold: assert property (p_hold) else $error("flow moved");
    property p_on; f_on [*2] |-> relay_out[0]; endproperty
    a_on: assert property (p_on) else $error("force on");
    property p_offr; f_off [*2] |-> !relay_out[0]; endproperty
    a_offr: assert property (p_offr) else $error("force off");
    // pin reaches the clear two flops and one edge later
    property p_mute; $fell(beeper) |-> $past(button_press, 3); endproperty
    a_mute: assert property (p_mute) else $error("beeper fell");
    c_flow: cover property (flow_valid && flow_value != 0);
    c_beep: cover property ($rose(beeper));
    c_force: cover property (f_on && relay_out[0]);
endmodule : pfr_props
bind pfr_top pfr_props #(.NREL(NREL)) i_pfr_props (.*);

// ---- bench/pfr_pulse_src.sv ----
/* Pulse transmitter model: square wave, half plus one clocks a state.
   Shares the bench clock; half of zero parks the line low. */
`timescale 1ns/1ns
module pfr_pulse_src (
    // clock and state length
    input wire logic clk,
    input wire logic [15:0] half,
    // pin
    output logic pulse_in
);
    logic [15:0] cnt = '0;
    initial pulse_in = 0;
    always @(posedge clk) begin
        cnt <= (cnt >= half) ? '0 : cnt + 16'h1;
        pulse_in <= #1 (half != '0) && (pulse_in ^ (cnt >= half));
    end
endmodule : pfr_pulse_src

// ---- bench/pfr_top_test.sv ----
/* Bench for pfr_top: serial, threshold, alarm and no-flow cases.
   Tenth tick shortened to 20 clocks; pulses from pfr_pulse_src. */
`timescale 1ns/1ns
`define CHK(n, e, v) chk(n, e, v)
module pfr_top_test;
    import pfr_pkg::*;
    int mismatches = 0, checks = 0, cyc = 0;
    logic clk = 0, resetn = 0, pulse_in, button_press = 0, peak_clear = 0;
    logic [3:0] max_pulse_rate_setting = 4'ha, relay_beep_enable = 4'h1;
    logic [19:0] pulses_per_unit_factor = 20'h1;
    logic [19:0] flow_scale_coefficient = 20'h3e8;
    logic [2:0] flow_scale_point = 3'h0;
    logic [8:0] refresh_window_min = 9'h1, no_flow_timeout = 9'h1ff;
    logic [8:0] serial_silence_timeout = 9'h1ff;
    logic [31:0] batch_count = '0, total_count = '0, flow_value, flow_peak;
    logic [3:0][2:0] relay_mode = {4{MODE_SERIAL}};
    logic [3:0][1:0] relay_source = '0, critical_reaction = '0;
    logic [3:0][19:0] first_threshold = {4{20'h64}};
    logic [3:0][19:0] second_threshold = {4{20'h186a0}};
    logic [3:0][19:0] relay_band_half_width = {4{20'ha}};
    logic [3:0][9:0] relay_on_delay = '0, relay_off_delay = '0;
    logic [3:0] relay_delay_minutes = '0, serial_cmd_state = '0;
    logic serial_cmd_valid = 0, serial_rx_activity = 0, flow_valid;
    logic critical_beep_enable = 0, over_rate, beeper;
    logic [3:0] relay_out, relay_led, relay_critical;
    logic [15:0] half = '0;
    pfr_top #(.TENTH_CYC(20)) i_pfr_top (.*);
    pfr_pulse_src i_pfr_pulse_src (.*);
    always #10 clk = ~clk;
    task chk(string n, logic [31:0] e, logic [31:0] v);
        checks++;
        if (v !== e) begin
            mismatches++;
            $display("BAD %s exp %0h got %0h", n, e, v);
        end
    endtask : chk
    // one serial command, counted as received serial data too
    task serial_cmd(input logic [3:0] s);
        @(posedge clk) #1 serial_cmd_state = s;
        serial_cmd_valid = 1;
        serial_rx_activity = 1;
        @(posedge clk) #1 serial_cmd_valid = 0;
        serial_rx_activity = 0;
    endtask : serial_cmd
    task final_report;
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // hang guard, run needs about 34000 cycles
    always @(posedge clk) if (++cyc > 90000) begin
        mismatches++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 resetn = 1;
        `CHK("reset", 4'h0, relay_out);
        serial_cmd(4'h5);
        repeat (2) @(negedge clk);
        `CHK("serial", 4'h5, relay_out);
        @(negedge clk) `CHK("led", 4'h5, relay_led);
        @(posedge clk) #1 relay_mode[0] = MODE_DISABLED;
        button_press = 1;
        repeat (6) @(posedge clk);
        #1 button_press = 0;
        `CHK("off", 4'h4, relay_out);
        `CHK("quiet", 1'b0, beeper);
        relay_mode = {MODE_OUTSIDE, MODE_INSIDE, MODE_DEENERGISE,
                      MODE_ENERGISE};
        half = 16'hbb8;
        repeat (3) do @(negedge clk); while (flow_valid !== 1'b1);
        repeat (3) @(negedge clk);
        `CHK("above", 4'h5, relay_out);
        `CHK("beep", 1'b1, beeper);
        `CHK("slow", 1'b0, over_rate);
        @(posedge clk) #1 critical_reaction = {4{REACT_ON}};
        half = 16'h7d0;
        do @(negedge clk); while (over_rate !== 1'b1);
        repeat (3) @(negedge clk);
        `CHK("crit", 4'hf, relay_critical);
        `CHK("force on", 4'hf, relay_out);
        @(posedge clk) #1 critical_reaction = {4{REACT_OFF}};
        repeat (3) @(negedge clk);
        `CHK("force off", 4'h0, relay_out);
        @(posedge clk) #1 critical_reaction = '0;
        half = '0;
        do @(negedge clk); while (!(flow_valid === 1'b1 && flow_value === '0));
        repeat (3) @(negedge clk);
        `CHK("idle", 4'ha, relay_out);
        // fastest windows span 200 or 201 ticks of one pulse
        `CHK("peak", 1'b1, flow_peak inside {[32'd4975:32'd5000]});
        @(posedge clk) #1 peak_clear = 1;
        @(posedge clk) #1 peak_clear = 0;
        `CHK("peak clr", 32'h0, flow_peak);
        // serial silence on relay 1
        @(posedge clk) #1 relay_mode[1] = MODE_SERIAL;
        serial_silence_timeout = 9'h3;
        serial_cmd(4'h5);
        repeat (40) @(posedge clk);
        #1 `CHK("heard", 1'b0, relay_critical[1]);
        repeat (60) @(posedge clk);
        #1 `CHK("silent", 1'b1, relay_critical[1]);
        // relay 0 from the total counter, delays of three tenths
        @(posedge clk) #1 relay_source[0] = SRC_TOTAL;
        relay_on_delay[0] = 10'h3;
        relay_off_delay[0] = 10'h3;
        total_count = 32'hc8;
        repeat (30) @(posedge clk);
        #1 `CHK("on early", 1'b0, relay_out[0]);
        repeat (50) @(posedge clk);
        #1 `CHK("on late", 1'b1, relay_out[0]);
        // two dips of exactly two ticks each must not add up
        total_count = '0;
        repeat (40) @(posedge clk);
        #1 total_count = 32'hc8;
        repeat (20) @(posedge clk);
        #1 total_count = '0;
        repeat (40) @(posedge clk);
        #1 `CHK("restart", 1'b1, relay_out[0]);
        repeat (40) @(posedge clk);
        #1 `CHK("off late", 1'b0, relay_out[0]);
        // two minute tenths: 1200 to 2400 clocks here
        relay_delay_minutes[0] = 1'b1;
        relay_on_delay[0] = 10'h2;
        total_count = 32'hc8;
        repeat (1150) @(posedge clk);
        #1 `CHK("min early", 1'b0, relay_out[0]);
        repeat (1300) @(posedge clk);
        #1 `CHK("min late", 1'b1, relay_out[0]);
        final_report();
    end
endmodule : pfr_top_test
